// File: hw/reset_source_control.sv
// Purpose: Reset-source control: threshold select, cause flags, resets
// Assumes: All side inputs synchronous to clk_sys
// Notes: Analog comparator and watchdog counter sit outside this block
//        Reset requests leave this block running; each cause applies its
//        own register effects here instead

`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Five threshold codes each select one trip voltage.
// - Code f0 disables low-voltage reset, no reset from that code.
// - Full reset only after low supply persists beyond filter time.
// - Low-voltage reset keeps the threshold register unchanged.
// - Undefined threshold code gives full reset after soft delay.
// - After undefined-code reset, threshold register returns to 66.
// - Low-voltage flag set on low-voltage reset; only software writes 0.
// - Threshold fault flag set on undefined code; software clears.
// - Upper four cause flag bits read zero.
// - Writing 55 to flash control register 1 resets whole device.
// - Watchdog timeout in run mode sets timeout flag.
// - Watchdog timeout in low power clears PC and SP only.
// - Watchdog timeout in low power sets timeout and powerdown flags.
// - Pin control invalid value reset sets software-code flag.
// - Low-voltage reset disabled in idle or sleep.
module reset_source_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Device side
  input wire logic supplyLow,
  input wire logic lowPowerMode,
  input wire logic wdtTimeout,
  input wire logic wdtCodeFault,
  output logic [7:0] thresholdCode,
  output rsc_pkg::rsc_rst_t rstOut,
  output logic irq
);
  import rsc_pkg::*;

  // ==========================================================
  // Reset synchroniser
  // Asserts at once, releases on the second edge so that all flops
  // leave reset together and none sees a half-released state
  logic rstMeta_q, rstSync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // ==========================================================
  // Register state
  logic [7:0] thr_q, thr_d, pin_q, pin_d;
  rsc_cause_t cause_q, cause_d;
  logic [1:0] pwr_q, pwr_d;
  logic [EV_N-1:0] irqStat_q, irqMask_q, irqMask_d, evSet;
  rsc_rst_t rst_q, rst_d;

  // ==========================================================
  // AXI write channel: address and data taken in either order
  // One write in flight: both readies stay low until the response is
  // taken, so a second request waits instead of being lost
  logic awHave_q, wHave_q, bvalid_q;
  logic [7:0] wAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire regWr = awHave_q && wHave_q && !bvalid_q;
  wire wrLane = regWr && wStrb_q[0];
  wire [7:0] wByte = wData_q[7:0];

  assign awready = !awHave_q && !bvalid_q;
  assign wready = !wHave_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Write address decode
  // Address bits [1:0] are ignored; registers live in byte lane 0
  wire wSelThr = wAddr_q == OFS_THR_SEL;
  wire wSelCause = wAddr_q == OFS_CAUSE;
  wire wSelFlash = wAddr_q == OFS_FLASH1;
  wire wSelPin = wAddr_q == OFS_PIN_CTRL;
  wire wSelPwr = wAddr_q == OFS_PWR_STAT;
  wire wSelStat = wAddr_q == OFS_IRQ_STAT;
  wire wSelMask = wAddr_q == OFS_IRQ_MASK;
  wire wMapped = wSelThr || wSelCause || wSelFlash || wSelPin ||
                 wSelPwr || wSelStat || wSelMask;

  // Capture halves, answer one cycle after both are held
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      bvalid_q <= 1'b0;
      wAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awHave_q <= 1'b1;
        wAddr_q <= {awaddr[7:2], 2'b00};
      end
      if (wTake) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (regWr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wMapped ? RESP_OKAY : RESP_DECERR;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire arTake = arvalid && arready;
  wire [7:0] rAddr = {araddr[7:2], 2'b00};
  wire rMapped = rAddr == OFS_THR_SEL || rAddr == OFS_CAUSE ||
                 rAddr == OFS_FLASH1 || rAddr == OFS_PIN_CTRL ||
                 rAddr == OFS_PWR_STAT || rAddr == OFS_IRQ_STAT ||
                 rAddr == OFS_IRQ_MASK;
  logic [31:0] rMux;
  // Read selection; flash control reads zero, upper cause bits zero
  // Offsets never overlap, so the order of the chain does not matter
  assign rMux =
    (rAddr == OFS_THR_SEL) ? {24'h00_0000, thr_q} :
    (rAddr == OFS_CAUSE) ? {28'h000_0000, cause_q} :
    (rAddr == OFS_PIN_CTRL) ? {24'h00_0000, pin_q} :
    (rAddr == OFS_PWR_STAT) ? {30'h0000_0000, pwr_q} :
    (rAddr == OFS_IRQ_STAT) ? {27'h000_0000, irqStat_q} :
    (rAddr == OFS_IRQ_MASK) ? {27'h000_0000, irqMask_q} :
    32'h0000_0000;

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Read data registered, held until taken
  // Unmapped offsets answer DECERR with zero data and no side effect
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arTake) begin
      rvalid_q <= 1'b1;
      rdata_q <= rMux;
      rresp_q <= rMapped ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Code classification
  // Anything neither a trip code nor the off code is a fault; the fault
  // flag is set from the register every cycle, not only at the reset
  wire thrValid = thr_q == THR_1V70 || thr_q == THR_1V90 ||
                  thr_q == THR_2V55 || thr_q == THR_3V15 ||
                  thr_q == THR_3V80;
  wire thrOff = thr_q == THR_OFF;
  wire thrBad = !thrValid && !thrOff;
  wire pinBad = pin_q != PIN_IO && pin_q != PIN_RES;
  // Comparator only armed on a valid code and outside low power
  wire lvrArmed = thrValid && !lowPowerMode;

  // ==========================================================
  // Delay timers: 0 = low-voltage filter, 1 = soft-reset delay.
  // A condition that goes away before expiry aborts the timer.
  // The filter sees the live code, so a switch to the off code or into
  // low power during a dip drops the pending reset.
  // One counter per delay keeps the two delays independent.
  logic [1:0] tmCond, tmFire;
  logic [CNT_W-1:0] tmLoad [2];
  assign tmCond = {thrBad || pinBad, lvrArmed && supplyLow};
  assign tmLoad[0] = LV_FILTER_CYC;
  assign tmLoad[1] = SOFT_DELAY_CYC;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gTimer
      logic [CNT_W-1:0] cnt_q;
      logic act_q;
      // Fires when held one cycle past the loaded count
      assign tmFire[gi] = tmCond[gi] && act_q && cnt_q == '0;
      always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
          cnt_q <= '0;
          act_q <= 1'b0;
        end else if (!tmCond[gi] || tmFire[gi]) begin
          act_q <= 1'b0;
        end else if (!act_q) begin
          cnt_q <= tmLoad[gi];
          act_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Reset causes
  // Requests are registered one-cycle pulses; a cause that stays true
  // reloads its timer and asks again after another full delay
  wire lvFire = tmFire[0];
  wire softFire = tmFire[1];
  wire flashMagic = wrLane && wSelFlash && wByte == FLASH_MAGIC;
  wire wdtRun = wdtTimeout && !lowPowerMode;
  wire wdtSleep = wdtTimeout && lowPowerMode;
  wire anyFull = lvFire || softFire || flashMagic || wdtRun;

  assign rst_d.fullReset = anyFull;
  assign rst_d.warmReset = wdtSleep;
  assign rst_d.lvrEnable = lvrArmed;

  // ==========================================================
  // Next values; hardware restore beats a write in the same cycle
  always_comb begin
    thr_d = thr_q;
    if (wrLane && wSelThr) thr_d = wByte;
    // Low-voltage reset leaves the code alone
    if (softFire && thrBad) thr_d = THR_POR;
  end

  // Every full request restores the pin control code; the warm reset
  // leaves it as software set it
  always_comb begin
    pin_d = pin_q;
    if (wrLane && wSelPin) pin_d = wByte;
    if (anyFull) pin_d = PIN_POR;
  end

  // Cause flags: write 0 clears, hardware set wins
  // A set meeting a clear keeps the flag, so software never loses an
  // event it has not yet read
  wire [3:0] causeClr = (wrLane && wSelCause) ? ~wByte[3:0] : 4'h0;
  always_comb begin
    cause_d = cause_q & ~causeClr;
    if (lvFire) cause_d.lowVolt = 1'b1;
    if (thrBad) cause_d.thrFault = 1'b1;
    if (softFire && pinBad) cause_d.swCode = 1'b1;
    if (wdtCodeFault) cause_d.wdtFault = 1'b1;
  end

  // Timeout and powerdown flags
  // A run-mode timeout leaves the powerdown flag as it was
  wire [1:0] pwrClr = (wrLane && wSelPwr) ? ~wByte[1:0] : 2'b00;
  always_comb begin
    pwr_d = pwr_q & ~pwrClr;
    if (wdtTimeout) pwr_d[PWR_TO] = 1'b1;
    if (wdtSleep) pwr_d[PWR_PDF] = 1'b1;
  end

  // Interrupt events and mask
  // Events are one-cycle strobes; the sticky status bits below hold them
  assign evSet[EV_LV] = lvFire;
  assign evSet[EV_THR] = softFire && thrBad;
  assign evSet[EV_SW] = softFire && pinBad;
  assign evSet[EV_FLASH] = flashMagic;
  assign evSet[EV_WDT] = wdtTimeout;
  assign irqMask_d = (wrLane && wSelMask) ? wByte[EV_N-1:0] : irqMask_q;

  // ==========================================================
  // Sticky status bits, write one to clear, set wins
  generate
    for (gi = 0; gi < EV_N; gi++) begin : gIrq
      wire clr = wrLane && wSelStat && wByte[gi];
      always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
          irqStat_q[gi] <= 1'b0;
        end else begin
          irqStat_q[gi] <= evSet[gi] || (irqStat_q[gi] && !clr);
        end
      end
    end
  endgenerate

  // ==========================================================
  // State registers; power-on reset is the master reset
  // Only the synchronised pin reset clears these, never a request that
  // this block raises itself
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      thr_q <= THR_POR;
      pin_q <= PIN_POR;
      cause_q <= '0;
      pwr_q <= 2'b00;
      irqMask_q <= '0;
      rst_q <= '0;
    end else begin
      thr_q <= thr_d;
      pin_q <= pin_d;
      cause_q <= cause_d;
      pwr_q <= pwr_d;
      irqMask_q <= irqMask_d;
      rst_q <= rst_d;
    end
  end

  // ==========================================================
  // Outputs
  // The interrupt is decoded from flops, so it rises the cycle after the
  // edge that sets its status bit
  assign thresholdCode = thr_q;
  assign rstOut = rst_q;
  assign irq = |(irqStat_q & irqMask_q);

endmodule // reset_source_control

`default_nettype wire

// File: hw/rsc_pkg.sv
// Purpose: Constants and types shared by the reset-source control block
// Assumes: 32-bit AXI4-Lite register access, 50 MHz system clock
// Notes: All register offsets are byte addresses of aligned words

`default_nettype none

package rsc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_THR_SEL = 8'h00; // threshold select
  localparam logic [7:0] OFS_CAUSE = 8'h04; // reset cause flags
  localparam logic [7:0] OFS_FLASH1 = 8'h08; // flash control reg 1
  localparam logic [7:0] OFS_PIN_CTRL = 8'h0c; // reset pin control
  localparam logic [7:0] OFS_PWR_STAT = 8'h10; // timeout / powerdown
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // sticky events
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // event enables

  // ==========================================================
  // Threshold codes
  localparam logic [7:0] THR_1V70 = 8'h66;
  localparam logic [7:0] THR_1V90 = 8'h55;
  localparam logic [7:0] THR_2V55 = 8'h33;
  localparam logic [7:0] THR_3V15 = 8'h99;
  localparam logic [7:0] THR_3V80 = 8'haa;
  localparam logic [7:0] THR_OFF = 8'hf0;
  localparam logic [7:0] THR_POR = 8'h66;

  // Reset pin control codes
  localparam logic [7:0] PIN_IO = 8'h55;
  localparam logic [7:0] PIN_RES = 8'haa;
  localparam logic [7:0] PIN_POR = 8'h55;

  // Flash control magic value that resets the device
  localparam logic [7:0] FLASH_MAGIC = 8'h55;

  // ==========================================================
  // Field positions
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_THR = 1;
  localparam int CAUSE_LV = 2;
  localparam int CAUSE_SW = 3;
  localparam int PWR_TO = 0;
  localparam int PWR_PDF = 1;
  localparam int EV_LV = 0;
  localparam int EV_THR = 1;
  localparam int EV_SW = 2;
  localparam int EV_FLASH = 3;
  localparam int EV_WDT = 4;
  localparam int EV_N = 5;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int LV_FILTER_NS = 2000; // low-voltage filter time
  localparam int SOFT_DELAY_NS = 1000; // soft-reset delay
  localparam int CNT_W = 12;
  // Least times: round up
  localparam logic [CNT_W-1:0] LV_FILTER_CYC =
    CNT_W'((LV_FILTER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SOFT_DELAY_CYC =
    CNT_W'((SOFT_DELAY_NS + CLK_NS - 1) / CLK_NS);

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // ==========================================================
  // Types
  typedef struct packed {
    logic swCode;
    logic lowVolt;
    logic thrFault;
    logic wdtFault;
  } rsc_cause_t;

  typedef struct packed {
    logic fullReset; // whole-device reset request
    logic warmReset; // clear PC and SP only
    logic lvrEnable; // comparator enabled
  } rsc_rst_t;

endpackage

`default_nettype wire

// File: testbench/rsc_props.sv
// Purpose: Port checks for reset_source_control
// Assumes: Low-supply dips never overlap other reset causes
// Notes: Bound into the block at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module rsc_props
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Read channel
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  // Device side
  input wire logic supplyLow,
  input wire logic lowPowerMode,
  input wire logic wdtTimeout,
  input wire logic [7:0] thresholdCode,
  input wire rsc_pkg::rsc_rst_t rstOut
);
  // ==========
  // Streak counters
  wire logic badCode = !(thresholdCode inside {THR_1V70, THR_1V90,
    THR_2V55, THR_3V15, THR_3V80, THR_OFF});
  wire logic lvCond = supplyLow && rstOut.lvrEnable;
  logic [7:0] lowCnt_q;
  logic [6:0] badCnt_q;
  logic fired_q;
  // Saturate so a long hold never wraps back to a small count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_q <= 8'h00;
      badCnt_q <= 7'h00;
      fired_q <= 1'b0;
    end else begin
      lowCnt_q <= lvCond ? lowCnt_q + {7'h00, lowCnt_q != 8'hc8} : 8'h00;
      badCnt_q <= badCode ? badCnt_q + {6'h00, badCnt_q != 7'h7f} : 7'h00;
      fired_q <= lvCond && (fired_q || rstOut.fullReset);
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_lvr_sleep_off: assert property (
    lowPowerMode && $past(lowPowerMode) |-> !rstOut.lvrEnable)
    else $error("lvr enabled in low power");
  a_lvr_code_off: assert property (
    thresholdCode == THR_OFF && $past(thresholdCode) == THR_OFF
    |-> !rstOut.lvrEnable) else $error("lvr enabled with off code");
  a_lv_not_early: assert property (
    lowCnt_q inside {[8'h01:8'h5f]} |-> !rstOut.fullReset)
    else $error("low supply reset too early");
  a_lv_must_fire: assert property (
    lowCnt_q == 8'h78 |-> fired_q) else $error("low supply reset missing");
  a_soft_not_early: assert property (
    badCnt_q inside {[7'h01:7'h2c]} |-> !rstOut.fullReset)
    else $error("soft reset too early");
  a_bad_code_restore: assert property (
    badCnt_q < 7'h3a) else $error("bad code never restored");
  a_wdt_run_reset: assert property (
    wdtTimeout && !lowPowerMode |-> ##[1:2] rstOut.fullReset)
    else $error("run timeout gave no reset");
  a_wdt_warm_only: assert property (
    wdtTimeout && lowPowerMode |-> ##[1:2]
    (rstOut.warmReset && !rstOut.fullReset)) else $error("no warm reset");
  a_full_one_cycle: assert property (
    rstOut.fullReset |=> !rstOut.fullReset) else $error("reset pulse long");
  a_read_upper_zero: assert property (
    rvalid |-> !arready && rdata[31:8] == 24'h0) else $error("read bad");
  c_lv_fire: cover property (lowCnt_q > 8'h5f && rstOut.fullReset);
  c_warm: cover property (rstOut.warmReset);
  c_restore: cover property ($past(badCode) && thresholdCode == THR_POR);
endmodule // rsc_props
bind reset_source_control rsc_props u_props (.clk_sys, .rst_n, .arready,
  .rdata, .rvalid, .supplyLow, .lowPowerMode, .wdtTimeout, .thresholdCode,
  .rstOut);
`default_nettype wire

// File: testbench/tb_reset_source_control.sv
// Purpose: Register-level bench for reset_source_control
// Assumes: Every task is entered just after a rising edge
// Notes: Reset pulses are counted, waits are bounded
`timescale 1ns/10ps
`default_nettype none
module tb_reset_source_control;
  import rsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic [7:0] awaddr, araddr, thresholdCode;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr, wb;
  logic supplyLow, lowPowerMode, wdtTimeout, wdtCodeFault;
  rsc_rst_t rstOut;
  int numErrors = 0;
  int nTests = 0;
  int nFull = 0;
  int nWarm = 0;
  int el;
  logic [7:0] codes [6] = '{THR_1V70, THR_1V90, THR_2V55, THR_3V15,
    THR_3V80, THR_OFF};
  reset_source_control dut (.clk_sys, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .supplyLow,
    .lowPowerMode, .wdtTimeout, .wdtCodeFault, .thresholdCode, .rstOut,
    .irq);
  always #10 clk_sys = ~clk_sys;
  // Pulse counters, non-blocking so readers see a settled value
  always @(posedge clk_sys) begin
    if (rstOut.fullReset === 1'b1) nFull <= nFull + 1;
    if (rstOut.warmReset === 1'b1) nWarm <= nWarm + 1;
  end
  // ==========
  // Helpers
  task automatic endSim();
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    nTests++;
    if (s !== e) begin
      numErrors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(string nm);
    numErrors++;
    $display("BAD %s exp done seen timeout", nm);
    endSim();
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 40);
    wb = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) tmo("write");
  endtask
  task automatic rd(logic [7:0] a);
    int n;
    logic ar;
    n = 0;
    ar = 1'b1;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 40);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) tmo("read");
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
    rd(a);
    chk(nm, rv, e);
  endtask
  task automatic hold(int k);
    supplyLow <= 1'b1;
    cyc(k);
    supplyLow <= 1'b0;
    cyc(4);
  endtask
  task automatic waitRst(int tgt, int lim);
    el = 0;
    while (nFull < tgt && el < lim) begin
      @(posedge clk_sys);
      el++;
    end
    if (nFull < tgt) tmo("reset");
  endtask
  task automatic pulseWdt();
    wdtTimeout <= 1'b1;
    cyc(1);
    wdtTimeout <= 1'b0;
    cyc(3);
  endtask
  // ==========
  // Main sequence
  initial begin
    rst_n <= 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} <= '0;
    {supplyLow, lowPowerMode, wdtTimeout, wdtCodeFault} <= '0;
    wstrb <= 4'h1;
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    rdc(OFS_THR_SEL, 32'h66, "thr por");
    rdc(OFS_CAUSE, 32'h0, "cause por");
    chk("rd okay", rr, RESP_OKAY);
    rd(8'h40);
    chk("unmapped", rr, RESP_DECERR);
    wr(8'h40, 32'h0);
    chk("wr unmapped", wb, RESP_DECERR);
    foreach (codes[i]) begin
      wr(OFS_THR_SEL, {24'h0, codes[i]});
      chk("wr okay", wb, RESP_OKAY);
      rdc(OFS_THR_SEL, {24'h0, codes[i]}, "thr code");
      chk("lvr on", rstOut.lvrEnable, codes[i] != THR_OFF);
    end
    hold(130);
    chk("off code", nFull, 0);
    wr(OFS_THR_SEL, 32'h33);
    hold(60);
    chk("short dip", nFull, 0);
    hold(130);
    chk("lv reset", nFull, 1);
    rdc(OFS_THR_SEL, 32'h33, "thr kept");
    chk("thr out", thresholdCode, 32'h33);
    wr(OFS_CAUSE, 32'hff);
    rdc(OFS_CAUSE, 32'h4, "lv flag");
    wr(OFS_CAUSE, 32'h0);
    rdc(OFS_CAUSE, 32'h0, "lv clear");
    lowPowerMode <= 1'b1;
    cyc(3);
    chk("lvr sleep", rstOut.lvrEnable, 1'b0);
    hold(130);
    chk("sleep dip", nFull, 1);
    pulseWdt();
    chk("warm", nWarm, 1);
    chk("warm no full", nFull, 1);
    rdc(OFS_PWR_STAT, 32'h3, "to pdf");
    rdc(OFS_THR_SEL, 32'h33, "warm keeps");
    lowPowerMode <= 1'b0;
    wr(OFS_PWR_STAT, 32'h0);
    pulseWdt();
    chk("wdt run", nFull, 2);
    rdc(OFS_PWR_STAT, 32'h1, "to run");
    wr(OFS_FLASH1, 32'h54);
    cyc(3);
    chk("flash other", nFull, 2);
    wstrb <= 4'h0;
    wr(OFS_FLASH1, {24'h0, FLASH_MAGIC});
    cyc(3);
    chk("flash no lane", nFull, 2);
    wstrb <= 4'h1;
    wr(OFS_FLASH1, {24'h0, FLASH_MAGIC});
    waitRst(3, 5);
    wr(OFS_THR_SEL, 32'h12);
    rdc(OFS_CAUSE, 32'h2, "fault flag");
    waitRst(4, 80);
    chk("soft delay", el >= 40, 1'b1);
    rdc(OFS_THR_SEL, 32'h66, "thr restored");
    wr(OFS_PIN_CTRL, {24'h0, PIN_RES});
    cyc(60);
    chk("pin res ok", nFull, 4);
    rdc(OFS_PIN_CTRL, 32'haa, "pin res");
    wr(OFS_PIN_CTRL, 32'h12);
    waitRst(5, 80);
    cyc(2);
    rdc(OFS_CAUSE, 32'ha, "sw flag");
    rdc(OFS_PIN_CTRL, 32'h55, "pin restored");
    wdtCodeFault <= 1'b1;
    cyc(1);
    wdtCodeFault <= 1'b0;
    wr(OFS_CAUSE, 32'h1);
    rdc(OFS_CAUSE, 32'h1, "fault cleared");
    chk("irq masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h1f);
    chk("irq on", irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h1f);
    chk("irq off", irq, 1'b0);
    endSim();
  end
endmodule // tb_reset_source_control
`default_nettype wire
